// ---- cip_pkg.sv ----
package cip_pkg;
    // Line counts per controller and in total
    localparam int unsigned LINES_PER_CTRL = 8;
    localparam int unsigned LINES_TOTAL = 16;
    // Primary line that carries the secondary group
    localparam logic [2:0] CASCADE_LINE = 3'h2;
    // Secondary line that stands in for the bus request of line 2
    localparam logic [3:0] SUBST_LINE = 4'h9;
    // Reset values of the vector bases and masks
    localparam logic [7:0] PRIM_BASE_RST = 8'h08;
    localparam logic [7:0] SEC_BASE_RST = 8'h70;
    localparam logic [15:0] MASK_RST = 16'hFFFF;
    // Fixed vector of the non-maskable error interrupt
    localparam logic [7:0] NMI_VECTOR = 8'h02;
endpackage

// ---- cip_ctrl8.sv ----
`timescale 1ns/10ps
// One eight-line controller: latches request edges, masks them and picks
// the lowest-numbered pending line. Lines flagged in LEVEL_LINES pass their
// input straight through, so a cascade input adds no cycle of lag.
module cip_ctrl8 #(
    parameter int unsigned N = 8,
    parameter logic [7:0] LEVEL_LINES = 8'h00
) (
    input wire logic clk, // System clock
    input wire logic rst, // Asynchronous reset, active high
    input wire logic [N-1:0] set_req, // Request edges or levels
    input wire logic [N-1:0] clr_req, // Pulse clears a pending line
    input wire logic [N-1:0] mask, // High masks the line
    output logic any_req, // Some unmasked line is pending
    output logic [2:0] win_idx // Index of the winning line
);
    logic [N-1:0] pending;
    logic [N-1:0] next_pending;
    logic [N-1:0] live;
    logic [N-1:0] held;

    // Lowest index wins
    function automatic logic [2:0] first_set(input logic [N-1:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    // Set wins over clear; level lines track their input
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : gen_line
            if (LEVEL_LINES[g]) begin : gen_level
                assign next_pending[g] = 1'b0; // Level lines keep no state
                assign held[g] = set_req[g];
            end else begin : gen_edge
                assign next_pending[g] = set_req[g] | (pending[g] & ~clr_req[g]);
                assign held[g] = pending[g];
            end
        end
    endgenerate

    assign live = held & ~mask;
    assign any_req = |live;
    assign win_idx = first_set(live); // [R4] [R5] [R12]

    // Pending store
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pending <= '0;
        end else begin
            pending <= next_pending;
        end
    end
endmodule

// ---- cip_unit.sv ----
`timescale 1ns/10ps
// What this block does
// [R1] Sixteen request lines across two eight-line controllers
// [R2] Secondary output drives primary request line 2
// [R3] Line 9 serves bus request 2, vector 0A
// [R4] Primary: line 0 highest, line 7 lowest
// [R5] Secondary 8 highest; group outranks lines 3-7
// [R6] All masked at reset; vectors loaded first
// [R7] Primary lines use vectors 08 through 0F
// [R8] Secondary lines use vectors 70 through 77
// [R9] System-management input ignores every mask
// [R10] Channel check raises NMI with vector 2
// [R11] Disabled optional sources never assert lines
// [R12] Only highest pending unmasked request presented
module cip_unit (
    input wire logic clk, // System clock, 125 MHz
    input wire logic rst, // Asynchronous reset, active high
    input wire logic [15:0] irq_req, // Request lines 0 to 15 except 2, rising edge
    input wire logic bus_irq2, // Expansion-bus request 2
    input wire logic [15:0] src_enable, // Low disables an optional source
    input wire logic [15:0] mask_in, // New mask value, high masks
    input wire logic mask_load, // Pulse loads mask_in
    input wire logic [7:0] prim_base_in, // Primary vector base to load
    input wire logic [7:0] sec_base_in, // Secondary vector base to load
    input wire logic redirect_9, // Line 9 takes the line 2 vector
    input wire logic cfg_load, // Pulse loads the vector setup
    input wire logic int_ack, // Pulse: processor took the vector
    input wire logic smi_req, // System-management request
    input wire logic chck_req, // Channel-check error from the slots
    output logic int_req, // Maskable interrupt to the processor
    output logic [7:0] int_vector, // Vector of the presented request
    output logic smi_out, // System-management interrupt
    output logic nmi_out, // Non-maskable interrupt
    output logic [7:0] nmi_vector // Vector of the non-maskable interrupt
);
    logic [15:0] req_prev;
    logic [15:0] mask;
    logic [7:0] prim_base;
    logic [7:0] sec_base;
    logic redir;
    logic configured;
    logic [3:0] shown_line;
    logic shown;
    wire [15:0] line_in;
    wire [15:0] line_edge;
    wire [7:0] sec_set;
    wire [7:0] prim_set;
    wire [15:0] clr_line;
    wire sec_any;
    wire [2:0] sec_idx;
    wire prim_any;
    wire [2:0] prim_idx;
    wire via_cascade;
    wire [3:0] win_line;
    wire [7:0] win_vector;
    wire [7:0] prim_mask;
    wire [7:0] sec_mask;

    // Vector of the winning line: primary base, secondary base, or the
    // line 2 vector when line 9 stands in for the bus request
    function automatic logic [7:0] vector_of(
        input logic cascade, // Winner sits behind line 2
        input logic [2:0] p_idx, // Primary winner
        input logic [2:0] s_idx, // Secondary winner
        input logic [7:0] p_base, // Primary vector base
        input logic [7:0] s_base, // Secondary vector base
        input logic redirect // Line 9 borrows the line 2 vector
    );
        logic [7:0] v;
        v = p_base + {5'h00, p_idx}; // [R7]
        if (cascade) begin
            if (redirect && ({1'b1, s_idx} == cip_pkg::SUBST_LINE)) begin
                v = p_base + {5'h00, cip_pkg::CASCADE_LINE}; // [R3]
            end else begin
                v = s_base + {5'h00, s_idx}; // [R8]
            end
        end
        return v;
    endfunction

    // Gated request lines; bus request 2 is routed to line 9
    genvar g;
    generate
        for (g = 0; g < cip_pkg::LINES_TOTAL; g++) begin : gen_src // [R1]
            if (g == int'(cip_pkg::SUBST_LINE)) begin : gen_sub
                assign line_in[g] = (irq_req[g] | bus_irq2) & src_enable[g]; // [R3] [R11]
            end else if (g == int'(cip_pkg::CASCADE_LINE)) begin : gen_casc
                assign line_in[g] = 1'b0; // [R2]
            end else begin : gen_plain
                assign line_in[g] = irq_req[g] & src_enable[g]; // [R11]
            end
        end
    endgenerate

    // Edge detection of the request lines
    assign line_edge = line_in & ~req_prev;
    assign sec_set = line_edge[15:8];
    assign prim_set = {line_edge[7:3], sec_any, line_edge[1:0]}; // [R2]
    assign prim_mask = {mask[7:3], 1'b0, mask[1:0]} | {8{~configured}}; // [R6]
    assign sec_mask = mask[15:8] | {8{~configured}}; // [R6]

    // Acknowledge clears the presented line and set still wins
    assign clr_line = (int_ack && shown) ? (16'h0001 << shown_line) : 16'h0000;

    // Secondary group, lines 8 to 15
    cip_ctrl8 #(
        .N(cip_pkg::LINES_PER_CTRL),
        .LEVEL_LINES(8'h00)
    ) u_sec (
        .clk(clk),
        .rst(rst),
        .set_req(sec_set),
        .clr_req(clr_line[15:8]),
        .mask(sec_mask),
        .any_req(sec_any),
        .win_idx(sec_idx)
    );

    // Primary group, lines 0 to 7, cascade on line 2
    cip_ctrl8 #(
        .N(cip_pkg::LINES_PER_CTRL),
        .LEVEL_LINES(8'h04)
    ) u_prim (
        .clk(clk),
        .rst(rst),
        .set_req(prim_set),
        .clr_req(clr_line[7:0]),
        .mask(prim_mask),
        .any_req(prim_any),
        .win_idx(prim_idx)
    );

    // Winner selection: cascade defers to the secondary choice
    assign via_cascade = (prim_idx == cip_pkg::CASCADE_LINE); // [R5]
    assign win_line = via_cascade ? {1'b1, sec_idx} : {1'b0, prim_idx}; // [R12]
    assign win_vector = vector_of(via_cascade, prim_idx, sec_idx, prim_base, sec_base, redir); // [R3] [R7] [R8]

    // Edge history
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_prev <= 16'h0000;
        end else begin
            req_prev <= line_in;
        end
    end

    // Mask store, all lines masked from reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mask <= cip_pkg::MASK_RST; // [R6]
        end else if (mask_load) begin
            mask <= mask_in;
        end
    end

    // Vector setup, taken on the load pulse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prim_base <= cip_pkg::PRIM_BASE_RST;
            sec_base <= cip_pkg::SEC_BASE_RST;
            redir <= 1'b0;
        end else if (cfg_load) begin
            prim_base <= prim_base_in;
            sec_base <= sec_base_in;
            redir <= redirect_9;
        end
    end

    // No maskable request reaches the processor until the setup is loaded
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            configured <= 1'b0; // [R6]
        end else if (cfg_load) begin
            configured <= 1'b1; // [R6]
        end
    end

    // Presented request and vector
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_req <= 1'b0;
            int_vector <= 8'h00;
        end else begin
            int_req <= prim_any; // [R12]
            int_vector <= prim_any ? win_vector : 8'h00;
        end
    end

    // Line behind the presented vector, for the acknowledge clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shown <= 1'b0;
            shown_line <= 4'h0;
        end else begin
            shown <= prim_any;
            shown_line <= win_line;
        end
    end

    // System-management path, no mask applies
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            smi_out <= 1'b0;
        end else begin
            smi_out <= smi_req; // [R9]
        end
    end

    // Channel-check path, no mask applies
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nmi_out <= 1'b0;
        end else begin
            nmi_out <= chck_req; // [R10]
        end
    end

    // Fixed vector of the non-maskable interrupt
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nmi_vector <= cip_pkg::NMI_VECTOR;
        end else begin
            nmi_vector <= cip_pkg::NMI_VECTOR; // [R10]
        end
    end
endmodule

// ---- cip_unit_sva.sv ----
`timescale 1ns/10ps
// Ties the unit's outputs to its inputs: vector ranges, masking, setup and the copied inputs
module cip_unit_sva (
    input wire logic clk, // System clock
    input wire logic rst, // Reset, active high
    input wire logic mask_load, // Mask load pulse
    input wire logic cfg_load, // Setup load pulse
    input wire logic smi_req, // System-management request
    input wire logic chck_req, // Channel-check error
    input wire logic int_req, // Maskable interrupt out
    input wire logic smi_out, // System-management out
    input wire logic nmi_out, // Non-maskable out
    input wire logic [15:0] irq_req, // Request lines
    input wire logic [15:0] src_enable, // Source enables
    input wire logic [15:0] mask_in, // Mask value to load
    input wire logic [7:0] int_vector, // Presented vector
    input wire logic [7:0] nmi_vector // Non-maskable vector
);
    logic cs;
    logic [15:0] mk;
    // Mask in force at this edge, a load counting at once
    wire logic [15:0] mkn = mask_load ? mask_in : mk;
    // Shadow of the configured flag and the mask
    always_ff @(posedge clk or posedge rst) begin
        if (rst) {cs, mk} <= {1'b0, cip_pkg::MASK_RST};
        else {cs, mk} <= {cs | cfg_load, mkn};
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_SMI: assert property (smi_out == $past(smi_req)) else $error("smi_out lag");
    AST_NMI: assert property (nmi_out == $past(chck_req)) else $error("nmi_out lag");
    AST_NMIV: assert property (nmi_vector == cip_pkg::NMI_VECTOR) else $error("nmi_vector");
    AST_IDLE: assert property (!int_req |-> int_vector == 8'h00) else $error("idle vector");
    AST_RANGE: assert property (int_req |-> int_vector[7:3] inside {5'h01, 5'h0E})
        else $error("vector range");
    AST_UNCFG: assert property (!cs |-> !int_req) else $error("early request");
    AST_MASKED: assert property (mkn == cip_pkg::MASK_RST |-> ##2 !int_req) else $error("masked request");
    AST_LINE0: assert property ((cs | cfg_load) && !mkn[0] && src_enable[0] && $rose(irq_req[0])
        |-> ##2 int_req && int_vector == cip_pkg::PRIM_BASE_RST) else $error("line 0 late");
    cover property (int_req && int_vector == 8'h0A);
    cover property (int_req && int_vector == 8'h77);
    cover property (smi_out && nmi_out);
endmodule

// ---- cip_host_model.sv ----
`timescale 1ns/10ps
// Host core: takes whatever vector is shown with a one-cycle pulse
module cip_host_model (
    input wire logic clk, // System clock
    input wire logic rst, // Reset, active high
    input wire logic int_req, // Request from the unit
    input wire logic [1:0] dly, // Extra wait after each take
    output logic int_ack, // Vector taken
    output logic [2:0] cnt // Cycles still to wait
);
    // Waits at least two edges after a take so the next vector has settled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) {int_ack, cnt} <= 4'h0;
        else if (int_ack) {int_ack, cnt} <= {2'h0, dly} + 4'h1;
        else if (cnt != 3'h0) cnt <= cnt - 3'h1;
        else int_ack <= int_req;
    end
endmodule

// ---- cip_unit_tb_top.sv ----
`timescale 1ns/10ps
// Raises request bursts and checks the order of the vectors the host takes
module cip_unit_tb_top;
    logic clk = 1'b0, rst = 1'b1, bus_irq2 = 1'b0, mask_load = 1'b0, redirect_9 = 1'b0, cfg_load = 1'b0;
    logic smi_req = 1'b0, chck_req = 1'b0, int_ack, int_req, smi_out, nmi_out;
    logic [15:0] irq_req = 16'h0001, src_enable = 16'hFFFF, mask_in = 16'h0000;
    logic [7:0] int_vector, nmi_vector;
    logic [7:0] q[$];
    logic [1:0] sq[$];
    logic [1:0] sys_v;
    logic [1:0] dly = 2'h0;
    int bad_count = 0, samples_checked = 0, seed = 32'hE7715944;
    int ord[15] = '{0, 1, 8, 9, 10, 11, 12, 13, 14, 15, 3, 4, 5, 6, 7};
    always #4 clk = ~clk;
    cip_unit u_cip_unit (.clk, .rst, .irq_req, .bus_irq2, .src_enable, .mask_in, .mask_load,
        .prim_base_in(cip_pkg::PRIM_BASE_RST), .sec_base_in(cip_pkg::SEC_BASE_RST), .redirect_9, .cfg_load,
        .int_ack, .smi_req, .chck_req, .int_req, .int_vector, .smi_out, .nmi_out, .nmi_vector);
    cip_host_model u_cip_host_model (.clk, .rst, .int_req, .dly, .int_ack, .cnt());
    // Random levels on the unmaskable inputs, quiet in reset; each level is noted
    always @(posedge clk) begin
        sys_v = rst ? 2'h0 : 2'($random(seed));
        {smi_req, chck_req} <= sys_v;
        sq.push_back(sys_v);
    end
    // One cycle after a level is sampled it must stand on the outputs
    always @(negedge clk) if (sq.size() > 1) chk_sys(sq.pop_front(), {smi_out, nmi_out}, nmi_vector);
    task automatic chk_sys(input logic [1:0] exp, input logic [1:0] got, input logic [7:0] vec);
        samples_checked++;
        if (got !== exp || vec !== cip_pkg::NMI_VECTOR) begin
            bad_count++;
            $display("unexpected at %0t: smi/nmi %b vector %h, wanted %b", $time, got, vec, exp);
        end
    endtask
    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: vector %h, wanted %h", $time, got, exp);
        end
    endtask
    // Takes the oldest note whenever the host accepts a vector
    always @(posedge clk) if (int_ack === 1'b1 && int_req === 1'b1) chk(q.size() > 0 ? q.pop_front() : 8'hXX, int_vector);
    task test_done;
        if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Raises lines at one edge (masked if m), then unmasks and configures
    task automatic burst(input logic [15:0] lines, input logic [15:0] en, input logic b2, m, rd);
        logic [15:0] set;
        set = (lines | {6'h00, b2, 9'h000}) & en & 16'hFFFB;
        foreach (ord[i])
            if (set[ord[i]]) q.push_back(ord[i] == 9 && rd ? 8'h0A : 8'(ord[i]) + (ord[i] < 8 ? 8'h08 : 8'h68));
        @(posedge clk);
        irq_req <= lines;
        bus_irq2 <= b2;
        src_enable <= en;
        mask_in <= {16{m}};
        mask_load <= 1'b1;
        dly <= 2'($random(seed));
        @(posedge clk);
        mask_in <= 16'h0000;
        redirect_9 <= rd;
        cfg_load <= 1'b1;
        @(posedge clk);
        mask_load <= 1'b0;
        cfg_load <= 1'b0;
        for (int i = 0; i < 400 && q.size() > 0; i++) @(posedge clk);
        if (q.size() > 0) chk(q.pop_front(), 8'hXX);
        q.delete();
        irq_req <= 16'h0000;
        bus_irq2 <= 1'b0;
    endtask
    // Line 0 waits unconfigured, then full, random and redirect bursts
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        mask_load <= 1'b1;
        @(posedge clk);
        mask_load <= 1'b0;
        repeat (4) @(posedge clk);
        burst(16'hFFFF, 16'hFFFF, 1'b0, 1'b1, 1'b0);
        repeat (8) burst(16'($random(seed)), 16'($random(seed)), 1'b0, 1'b1, 1'b0);
        burst(16'h0003, 16'hFFFF, 1'b1, 1'b0, 1'b1);
        test_done;
    end
    // Cuts a hang short
    initial begin
        #100000 bad_count++;
        test_done;
    end
endmodule
bind cip_unit cip_unit_sva u_cip_unit_sva (.clk, .rst, .mask_load, .cfg_load, .smi_req, .chck_req, .int_req,
    .smi_out, .nmi_out, .irq_req, .src_enable, .mask_in, .int_vector, .nmi_vector);
